// >>> logic/fadc_regs.vh
// Constants for the flash converter code correction block
`ifndef FADC_REGS_VH
`define FADC_REGS_VH
`define FADC_RES_BITS 10
`define FADC_WORD_BITS 11
`define FADC_LOW_TOP 8
`define FADC_MSB 9
`define FADC_OVR 10
`define FADC_FIFO_DEPTH 16
`define FADC_FIFO_AW 4
`define FADC_WORD_RST 11'h000
`define FADC_MID_CODE 10'h200
`define FADC_FULL_CODE 10'h3ff
`define FADC_ST_RUN 2'h1
`define FADC_ST_HOLD 2'h2
`endif

// >>> logic/fadc_fifo.v
// Parameterised sample FIFO with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
`include "fadc_regs.vh"
module fadc_fifo #(
	parameter WIDTH = 12,
	parameter DEPTH = `FADC_FIFO_DEPTH,
	parameter AW = `FADC_FIFO_AW
) (
	input wire i_clk,
	input wire i_rst,
	input wire i_in_valid,
	output wire o_in_ready,
	input wire [WIDTH-1:0] i_in_data,
	output wire o_out_valid,
	input wire i_out_ready,
	output wire [WIDTH-1:0] o_out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0] wr_reg;
	reg [AW:0] rd_reg;
	wire full = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
	wire empty = (wr_reg == rd_reg);
	wire push = i_in_valid && !full;
	wire pop = !empty && i_out_ready;
	assign o_in_ready = !full;
	assign o_out_valid = !empty;
	// Memory output read directly; depth is small enough for distributed storage
	assign o_out_data = mem[rd_reg[AW-1:0]];
	always @(posedge i_clk) begin
		if (push) begin
			mem[wr_reg[AW-1:0]] <= i_in_data;
		end
	end
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wr_reg <= {(AW+1){1'b0}};
			rd_reg <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_reg <= wr_reg + 1'b1;
			end
			if (pop) begin
				rd_reg <= rd_reg + 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// >>> logic/fadc_correct.v
// Thermometer repair, Gray encode, offset-binary output and complement controls
// Notes on behaviour
// - A comparator pattern is valid only when all ones sit below one boundary and zeros above.
// - Any departure from that form, such as a stray zero or one, flags an error.
// - On error each position is repaired by a vote over its neighbouring comparators.
// - For a single stray bit the repaired code is the true code or within one step of it.
// - The repaired thermometer is encoded to Gray code before turning into binary.
// - With no complementing the word is over-range then ten offset-binary bits, MSB first.
// - The low-group complement inverts result bits zero through eight only.
// - The high-group complement inverts the result MSB and over-range flag together.
// - With no complementing, over-range is set only above the top comparator, and then all result bits read one.
`timescale 1ns/1ns
`default_nettype none
`include "fadc_regs.vh"
module fadc_correct #(
	parameter NBITS = `FADC_RES_BITS,
	parameter NCMP = (1 << `FADC_RES_BITS)
) (
	input wire i_clk,
	input wire i_rst,
	input wire [NCMP-1:0] i_comparators,
	input wire i_low_group_complement,
	input wire i_high_group_complement,
	input wire i_out_ready,
	output wire o_out_valid,
	output wire [NBITS-1:0] o_result_bits,
	output wire o_over_range_flag,
	output wire o_error_pulse,
	output reg o_error_reg,
	output reg o_overflow_reg
);
	// Comparator NCMP-1 sits one step above the top reference level
	reg [NCMP-1:0] cmp_reg;
	reg [NCMP-1:0] fixed;
	reg [NCMP-1:0] edge_map;
	reg bad;
	reg [NBITS:0] gray;
	reg [NBITS:0] bin;
	reg [`FADC_WORD_BITS-1:0] word_reg;
	reg [`FADC_WORD_BITS-1:0] word_next;
	reg [1:0] state_reg;
	reg [1:0] state_next;
	wire fifo_ready;
	integer k;
	integer code;

	function maj3;
		input a;
		input b;
		input c;
		begin
			maj3 = (a & b) | (a & c) | (b & c);
		end
	endfunction

	function [NBITS:0] gray2bin;
		input [NBITS:0] g;
		integer j;
		begin
			gray2bin[NBITS] = g[NBITS];
			for (j = NBITS - 1; j >= 0; j = j - 1) begin
				gray2bin[j] = gray2bin[j+1] ^ g[j];
			end
		end
	endfunction

	// Error detection over the raw pattern
	always @* begin
		bad = 1'b0;
		for (k = 0; k < NCMP - 1; k = k + 1) begin
			if (!cmp_reg[k] && cmp_reg[k+1]) begin
				bad = 1'b1;
			end
		end
	end

	// Three-input neighbour vote; removes single bubbles, leaving at most one step of error
	genvar g;
	generate
		for (g = 0; g < NCMP; g = g + 1) begin : g_vote
			if (g == 0) begin : g_lo
				always @* fixed[g] = maj3(1'b1, cmp_reg[g], cmp_reg[g+1]);
			end else if (g == NCMP - 1) begin : g_hi
				always @* fixed[g] = maj3(cmp_reg[g-1], cmp_reg[g], 1'b0);
			end else begin : g_mid
				always @* begin
					if (bad) begin
						fixed[g] = maj3(cmp_reg[g-1], cmp_reg[g], cmp_reg[g+1]);
					end else begin
						fixed[g] = cmp_reg[g];
					end
				end
			end
		end
	endgenerate

	// One-hot boundary then Gray code by OR of matching positions
	always @* begin
		for (k = 0; k < NCMP; k = k + 1) begin
			if (k == NCMP - 1) begin
				edge_map[k] = fixed[k];
			end else begin
				edge_map[k] = fixed[k] & !fixed[k+1];
			end
		end
		gray = {(NBITS+1){1'b0}};
		code = 0;
		for (k = 0; k < NCMP; k = k + 1) begin
			code = (k + 1) ^ ((k + 1) >> 1);
			if (edge_map[k]) begin
				gray = gray | code[NBITS:0];
			end
		end
		bin = gray2bin(gray);
	end

	// Output word assembly
	always @* begin
		if (bin[NBITS]) begin
			word_next = {1'b1, `FADC_FULL_CODE};
		end else begin
			word_next = {1'b0, bin[NBITS-1:0]};
		end
		if (i_low_group_complement) begin
			word_next[`FADC_LOW_TOP:0] = ~word_next[`FADC_LOW_TOP:0];
		end
		if (i_high_group_complement) begin
			word_next[`FADC_OVR:`FADC_MSB] = ~word_next[`FADC_OVR:`FADC_MSB];
		end
	end

	// Stall state: HOLD while the FIFO refuses a word
	always @* begin
		case (state_reg)
			`FADC_ST_RUN: state_next = fifo_ready ? `FADC_ST_RUN : `FADC_ST_HOLD;
			`FADC_ST_HOLD: state_next = fifo_ready ? `FADC_ST_RUN : `FADC_ST_HOLD;
			default: state_next = `FADC_ST_RUN;
		endcase
	end

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cmp_reg <= {NCMP{1'b0}};
			word_reg <= `FADC_WORD_RST;
			state_reg <= `FADC_ST_RUN;
			o_error_reg <= 1'b0;
			o_overflow_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cmp_reg <= i_comparators;
			word_reg <= word_next;
			o_error_reg <= bad;
			// Sticky until reset; a lost sample is never silently hidden
			o_overflow_reg <= o_overflow_reg | !fifo_ready;
		end
	end

	reg val_reg;
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			val_reg <= 1'b0;
		end else begin
			val_reg <= 1'b1;
		end
	end
	assign o_error_pulse = o_error_reg;

	// A flash converter cannot pause its input, so a full FIFO drops the newest word
	fadc_fifo #(
		.WIDTH(`FADC_WORD_BITS),
		.DEPTH(`FADC_FIFO_DEPTH),
		.AW(`FADC_FIFO_AW)
	) u_fifo (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_in_valid(val_reg),
		.o_in_ready(fifo_ready),
		.i_in_data(word_reg),
		.o_out_valid(o_out_valid),
		.i_out_ready(i_out_ready),
		.o_out_data({o_over_range_flag, o_result_bits})
	);
endmodule
`default_nettype wire

// >>> testbench/fadc_correct_assertions.sv
// Port checks for the code correction block
`timescale 1ns/1ns
`default_nettype none
module fadc_correct_assertions #(parameter NBITS = 10, parameter NCMP = 1024) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [NCMP-1:0] i_comparators,
	input wire logic i_out_ready,
	input wire logic o_out_valid,
	input wire logic [NBITS-1:0] o_result_bits,
	input wire logic o_over_range_flag,
	input wire logic o_error_pulse,
	input wire logic o_error_reg,
	input wire logic o_overflow_reg
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// A zero under a one anywhere breaks the thermometer
	wire bub = |(~i_comparators[NCMP-2:0] & i_comparators[NCMP-1:1]);
	property p_err; !$past(i_rst) && !$past(i_rst, 2) |-> o_error_reg == $past(bub, 2); endproperty
	a_err: assert property (p_err) else $error("error flag");
	property p_pulse; o_error_pulse == o_error_reg; endproperty
	a_pulse: assert property (p_pulse) else $error("error pulse");
	property p_sticky; $past(o_overflow_reg) |-> o_overflow_reg; endproperty
	a_sticky: assert property (p_sticky) else $error("overflow lost");
	property p_ovf; $rose(o_overflow_reg) |-> $past(o_out_valid); endproperty
	a_ovf: assert property (p_ovf) else $error("overflow cause");
	property p_head; o_out_valid && !i_out_ready |=>
		o_out_valid && $stable({o_over_range_flag, o_result_bits}); endproperty
	a_head: assert property (p_head) else $error("head moved");
	property p_stream; o_out_valid && i_out_ready |=> o_out_valid; endproperty
	a_stream: assert property (p_stream) else $error("stream gap");
	property p_rst; $fell(i_rst) |-> !o_out_valid [*2] ##1 o_out_valid; endproperty
	a_rst: assert property (p_rst) else $error("first word");
	property p_clr; $fell(i_rst) |-> !o_error_reg && !o_overflow_reg; endproperty
	a_clr: assert property (p_clr) else $error("flags after reset");
endmodule
bind fadc_correct fadc_correct_assertions #(.NBITS(NBITS), .NCMP(NCMP)) u_chk (
	.i_clk(i_clk), .i_rst(i_rst), .i_comparators(i_comparators), .i_out_ready(i_out_ready),
	.o_out_valid(o_out_valid), .o_result_bits(o_result_bits),
	.o_over_range_flag(o_over_range_flag), .o_error_pulse(o_error_pulse),
	.o_error_reg(o_error_reg), .o_overflow_reg(o_overflow_reg));
`default_nettype wire

// >>> testbench/fadc_sink.sv
// Downstream model keeping the latest sample word taken
`timescale 1ns/1ns
`default_nettype none
module fadc_sink (
	input wire logic i_clk,
	input wire logic i_valid,
	input wire logic [10:0] i_word,
	input wire logic i_stall,
	output logic o_ready,
	output logic [10:0] o_last
);
	// Stalling withholds ready; a word counts only on a handshake edge
	assign o_ready = !i_stall;
	initial o_last = '0;
	always @(posedge i_clk) begin
		if (i_valid && o_ready) begin
			o_last <= i_word;
		end
	end
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// Testbench for the code correction block
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic i_clk = 0, i_rst = 1, lo = 0, hi = 0, stall = 0;
	logic [1023:0] cmp = '0;
	logic [10:0] w;
	wire logic rdy, vld, over_range_flag, epl, err, ovf;
	wire logic [9:0] res;
	wire logic [10:0] last;
	int err_count = 0, compares = 0, n;
	// Bits 11:0 count, 12 low, 13 high, 14 bubbles
	int t[12] = '{0, 1, 511, 512, 1023, 1024, 'h1400, 'h2400, 'h3400, 'h3200, 'h412c, 'h512c};
	initial forever #20 i_clk = ~i_clk;
	fadc_correct dut (.i_clk(i_clk), .i_rst(i_rst), .i_comparators(cmp),
		.i_low_group_complement(lo), .i_high_group_complement(hi), .i_out_ready(rdy),
		.o_out_valid(vld), .o_result_bits(res), .o_over_range_flag(over_range_flag),
		.o_error_pulse(epl), .o_error_reg(err), .o_overflow_reg(ovf));
	fadc_sink sink (.i_clk(i_clk), .i_valid(vld), .i_word({over_range_flag, res}), .i_stall(stall),
		.o_ready(rdy), .o_last(last));
	task check(input logic [10:0] seen, input logic [10:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	endtask
	task tally_and_finish;
		if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge i_clk);
		#1 i_rst = 0;
		foreach (t[i]) begin
			n = t[i] & 'hfff;
			lo = t[i][12];
			hi = t[i][13];
			// Stray zero below and stray one above the boundary
			cmp = ~({1024{1'b1}} << n) ^ (t[i][14] ? 1024'h21 << (n - 3) : '0);
			w = ((n > 1023) ? 11'h7ff : 11'(n)) ^ {hi, hi, {9{lo}}};
			repeat (6) @(posedge i_clk);
			#1 check(last, w);
			check(11'(err), 11'(t[i][14]));
		end
		check(11'(ovf), 11'h0);
		stall = 1;
		repeat (20) @(posedge i_clk);
		#1 check(last, w);
		check(11'({vld, ovf}), 11'h3);
		tally_and_finish();
	end
endmodule
`default_nettype wire
